// >>> core/svwd_pkg.sv
/*
 * Shared constants and types of the supervisor watchdog reset block.
 * Assumes a single 10 MHz reference clock; every period is counted in
 * ticks of a 1 us timebase derived from that clock.
 */
package svwd_pkg;

	// reference clock
	localparam int CLK_HZ = 10_000_000;
	localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;

	// internal timebase
	localparam int TICK_NS = 1000;
	localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
	localparam int DIV_W = 4;
	localparam logic [DIV_W-1:0] TICK_LAST = DIV_W'(TICK_CYCLES - 1);

	// period counters, in ticks
	localparam int CNT_W = 25;

	// reset hold period options, minimum values in us (rounded up to ticks)
	localparam longint HOLD_A_US = 1000;
	localparam longint HOLD_B_US = 20000;
	localparam longint HOLD_C_US = 140000;
	localparam longint HOLD_D_US = 1120000;
	localparam logic [CNT_W-1:0] HOLD_A_TICKS = CNT_W'((HOLD_A_US * 1000 + TICK_NS - 1) / TICK_NS);
	localparam logic [CNT_W-1:0] HOLD_B_TICKS = CNT_W'((HOLD_B_US * 1000 + TICK_NS - 1) / TICK_NS);
	localparam logic [CNT_W-1:0] HOLD_C_TICKS = CNT_W'((HOLD_C_US * 1000 + TICK_NS - 1) / TICK_NS);
	localparam logic [CNT_W-1:0] HOLD_D_TICKS = CNT_W'((HOLD_D_US * 1000 + TICK_NS - 1) / TICK_NS);

	// watchdog period options, typical values in us (rounded down to ticks)
	localparam longint WD_W_US = 6300;
	localparam longint WD_X_US = 102000;
	localparam longint WD_Y_US = 1600000;
	localparam longint WD_Z_US = 25600000;
	localparam logic [CNT_W-1:0] WD_W_TICKS = CNT_W'((WD_W_US * 1000) / TICK_NS);
	localparam logic [CNT_W-1:0] WD_X_TICKS = CNT_W'((WD_X_US * 1000) / TICK_NS);
	localparam logic [CNT_W-1:0] WD_Y_TICKS = CNT_W'((WD_Y_US * 1000) / TICK_NS);
	localparam logic [CNT_W-1:0] WD_Z_TICKS = CNT_W'((WD_Z_US * 1000) / TICK_NS);

	// floating kick: internal refresh at 7/8 of the watchdog period
	localparam int FREERUN_NUM = 7;
	localparam int FREERUN_DEN = 8;

	// glitch rejection
	localparam int FILT_W = 8;
	localparam int MR_GLITCH_NS = 100;
	localparam int MR_FILT_CYC = MR_GLITCH_NS / CLK_PERIOD_NS + 1;
	localparam int SUPPLY_DIP_NS = 4000;
	localparam int SUPPLY_FILT_CYC = SUPPLY_DIP_NS / CLK_PERIOD_NS;
	localparam int KICK_PULSE_NS = 50;

	// option straps are sampled this many cycles after reset release
	localparam logic [1:0] STRAP_WAIT = 2'h3;

	typedef enum logic [1:0] {
		ST_FORCED = 2'b00,
		ST_HOLD = 2'b01,
		ST_RUN = 2'b10
	} svwd_state_t;

	typedef enum logic [1:0] {
		CAUSE_NONE = 2'b00,
		CAUSE_SUPPLY = 2'b01,
		CAUSE_MANUAL = 2'b10,
		CAUSE_WATCHDOG = 2'b11
	} svwd_cause_t;

endpackage

// >>> core/svwd_filter.sv
/*
 * Level filter: the output follows the input only after the input has
 * differed from it for LEN consecutive cycles.
 * Assumes its input is already synchronised to ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module svwd_filter #(
	parameter int LEN = 2,
	parameter logic INIT = 1'b1
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic din,
	output logic dout
);
	import svwd_pkg::*;

	typedef struct packed {
		logic [FILT_W-1:0] cnt;
		logic q;
	} svwd_filt_t;

	localparam logic [FILT_W-1:0] LEN_LAST = FILT_W'(LEN - 1);

	svwd_filt_t s;
	svwd_filt_t next_s;

	always_comb begin
		next_s = s;
		if (din == s.q) begin
			next_s.cnt = '0;
		end else if (s.cnt >= LEN_LAST) begin
			next_s.q = din;
			next_s.cnt = '0;
		end else begin
			next_s.cnt = s.cnt + FILT_W'(1);
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			s.cnt <= '0;
			s.q <= INIT;
		end else begin
			s <= next_s;
		end
	end

	assign dout = s.q;

endmodule // svwd_filter

`default_nettype wire

// >>> core/svwd_supervisor.sv
/*
 * Processor supervisor: supply, manual-reset and watchdog monitoring that
 * drive a held reset output in push/pull, active-high and open-drain form.
 * Assumes an analog comparator flags the supply against the trip level,
 * pad sense lines tell whether the manual-reset and kick pins are driven,
 * and the option straps are static pins.
 */
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - reset stays asserted while manual_reset_n is held low
// - after manual_reset_n rises, reset is held one further full hold period
// - short low glitches on manual_reset_n, about 100ns, never start reset
// - an undriven manual_reset_n reads as inactive high
// - no kick level change for a whole watchdog period asserts reset
// - any kick edge clears the watchdog timer; reset assertion clears it too
// - watchdog timer held at zero during reset, counts only after release
// - floating kick disables watchdog; internal refresh every 7/8 period
// - open-drain output pulls low only while reset is asserted
// - supply dips under 4us, or 200ns full dips, do not start reset
// - reset while supply below trip level, then held one hold period
// - on hold period expiry reset releases and watchdog restarts from zero
// - hold period is one of four options: 1ms, 20ms, 140ms, 1.12s minimum
// - watchdog period is one of four options: 6.3ms, 102ms, 1.6s, 25.6s
module svwd_supervisor #(
	parameter logic [svwd_pkg::CNT_W-1:0] HOLD_TICKS_A = svwd_pkg::HOLD_A_TICKS,
	parameter logic [svwd_pkg::CNT_W-1:0] HOLD_TICKS_B = svwd_pkg::HOLD_B_TICKS,
	parameter logic [svwd_pkg::CNT_W-1:0] HOLD_TICKS_C = svwd_pkg::HOLD_C_TICKS,
	parameter logic [svwd_pkg::CNT_W-1:0] HOLD_TICKS_D = svwd_pkg::HOLD_D_TICKS,
	parameter logic [svwd_pkg::CNT_W-1:0] WD_TICKS_W = svwd_pkg::WD_W_TICKS,
	parameter logic [svwd_pkg::CNT_W-1:0] WD_TICKS_X = svwd_pkg::WD_X_TICKS,
	parameter logic [svwd_pkg::CNT_W-1:0] WD_TICKS_Y = svwd_pkg::WD_Y_TICKS,
	parameter logic [svwd_pkg::CNT_W-1:0] WD_TICKS_Z = svwd_pkg::WD_Z_TICKS,
	parameter logic [svwd_pkg::DIV_W-1:0] TICK_LAST_CYC = svwd_pkg::TICK_LAST
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic manualResetN,
	input wire logic manualResetDriven,
	input wire logic watchdogKick,
	input wire logic watchdogKickDriven,
	input wire logic supplyAboveTrip,
	input wire logic [1:0] holdSel,
	input wire logic [1:0] wdSel,
	output logic resetN,
	output logic resetHigh,
	output logic resetOdOut,
	output logic resetOdOe,
	output svwd_pkg::svwd_cause_t resetCause
);
	import svwd_pkg::*;

	typedef struct packed {
		logic [1:0] mrSync;
		logic [1:0] mrDrvSync;
		logic [1:0] kickSync;
		logic [1:0] kickDrvSync;
		logic [1:0] supSync;
		logic [1:0][1:0] holdSelSync;
		logic [1:0][1:0] wdSelSync;
		logic [1:0] strapWait;
		logic [1:0] holdSelQ;
		logic [1:0] wdSelQ;
		logic kickPrev;
		logic [DIV_W-1:0] divCnt;
		svwd_state_t state;
		logic [CNT_W-1:0] holdCnt;
		logic [CNT_W-1:0] wdCnt;
		logic refreshPulse;
		logic resetN;
		logic resetHigh;
		svwd_cause_t cause;
	} svwd_core_t;

	svwd_core_t s;
	svwd_core_t next_s;

	logic mrEff;
	logic mrOk;
	logic supplyOk;
	logic tick;
	logic kickEdge;
	logic forceSrc;
	logic wdEnabled;
	logic [CNT_W-1:0] holdLimit;
	logic [CNT_W-1:0] wdLimit;
	logic [CNT_W-1:0] refreshAt;

	// one of four factory options, picked by a two-bit strap
	function automatic logic [CNT_W-1:0] pick_option(
		input logic [1:0] sel,
		input logic [CNT_W-1:0] opt0,
		input logic [CNT_W-1:0] opt1,
		input logic [CNT_W-1:0] opt2,
		input logic [CNT_W-1:0] opt3
	);
		logic [CNT_W-1:0] r;
		r = opt0;
		case (sel)
			2'h0: r = opt0;
			2'h1: r = opt1;
			2'h2: r = opt2;
			default: r = opt3;
		endcase
		return r;
	endfunction

	// an undriven pin reads high, as through a pull-up
	assign mrEff = s.mrSync[1] | ~s.mrDrvSync[1];

	// low must last beyond the glitch width before it counts
	svwd_filter #(
		.LEN(MR_FILT_CYC),
		.INIT(1'b1)
	) u_mr_filter (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.din(mrEff),
		.dout(mrOk)
	);

	// starts low so power-up always runs a full hold period
	svwd_filter #(
		.LEN(SUPPLY_FILT_CYC),
		.INIT(1'b0)
	) u_supply_filter (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.din(s.supSync[1]),
		.dout(supplyOk)
	);

	assign holdLimit = pick_option(s.holdSelQ, HOLD_TICKS_A, HOLD_TICKS_B,
		HOLD_TICKS_C, HOLD_TICKS_D);
	assign wdLimit = pick_option(s.wdSelQ, WD_TICKS_W, WD_TICKS_X,
		WD_TICKS_Y, WD_TICKS_Z);

	// product stays below 2^31 for the largest option
	assign refreshAt = CNT_W'((32'(wdLimit) * FREERUN_NUM) / FREERUN_DEN);

	assign tick = (s.divCnt == TICK_LAST_CYC);
	assign wdEnabled = s.kickDrvSync[1];
	// kick pulses shorter than one clock period (100 ns) can be missed
	assign kickEdge = wdEnabled & (s.kickSync[1] ^ s.kickPrev);
	assign forceSrc = ~supplyOk | ~mrOk;

	always_comb begin
		next_s = s;

		// two-stage synchronisers on every pin
		next_s.mrSync = {s.mrSync[0], manualResetN};
		next_s.mrDrvSync = {s.mrDrvSync[0], manualResetDriven};
		next_s.kickSync = {s.kickSync[0], watchdogKick};
		next_s.kickDrvSync = {s.kickDrvSync[0], watchdogKickDriven};
		next_s.supSync = {s.supSync[0], supplyAboveTrip};
		next_s.holdSelSync = {s.holdSelSync[0], holdSel};
		next_s.wdSelSync = {s.wdSelSync[0], wdSel};
		next_s.kickPrev = s.kickSync[1];
		next_s.refreshPulse = 1'b0;

		// straps are sampled in each of the first three cycles; the last sample has crossed both stages
		if (s.strapWait != STRAP_WAIT) begin
			next_s.strapWait = s.strapWait + 2'h1;
			next_s.holdSelQ = s.holdSelSync[1];
			next_s.wdSelQ = s.wdSelSync[1];
		end

		// timebase divider
		if (tick) begin
			next_s.divCnt = '0;
		end else begin
			next_s.divCnt = s.divCnt + DIV_W'(1);
		end

		case (s.state)
			ST_FORCED: begin
				next_s.wdCnt = '0;
				next_s.holdCnt = '0;
				if (!supplyOk) begin
					next_s.cause = CAUSE_SUPPLY;
				end else if (!mrOk) begin
					next_s.cause = CAUSE_MANUAL;
				end
				if (!forceSrc) begin
					next_s.state = ST_HOLD;
				end
			end
			ST_HOLD: begin
				next_s.wdCnt = '0;
				if (forceSrc) begin
					next_s.state = ST_FORCED;
				end else if (tick) begin
					// one extra tick: the first tick may be partial, hold stays a minimum
					if (s.holdCnt >= holdLimit) begin
						next_s.state = ST_RUN;
						next_s.holdCnt = '0;
					end else begin
						next_s.holdCnt = s.holdCnt + CNT_W'(1);
					end
				end
			end
			ST_RUN: begin
				if (forceSrc) begin
					next_s.state = ST_FORCED;
					next_s.wdCnt = '0;
				end else if (kickEdge) begin
					next_s.wdCnt = '0;
				end else if (!wdEnabled && s.wdCnt >= refreshAt) begin
					// internal low-high-low refresh while the kick floats
					next_s.wdCnt = '0;
					next_s.refreshPulse = 1'b1;
				end else if (tick) begin
					if (wdEnabled && s.wdCnt + CNT_W'(1) >= wdLimit) begin
						next_s.state = ST_HOLD;
						next_s.wdCnt = '0;
						next_s.holdCnt = '0;
						next_s.cause = CAUSE_WATCHDOG;
					end else begin
						next_s.wdCnt = s.wdCnt + CNT_W'(1);
					end
				end
			end
			default: begin
				next_s.state = ST_FORCED;
			end
		endcase

		// outputs registered from the next state, so they move with it
		next_s.resetN = (next_s.state == ST_RUN);
		next_s.resetHigh = (next_s.state != ST_RUN);
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			s.mrSync <= 2'h3;
			s.mrDrvSync <= 2'h0;
			s.kickSync <= 2'h0;
			s.kickDrvSync <= 2'h0;
			s.supSync <= 2'h0;
			s.holdSelSync <= 4'h0;
			s.wdSelSync <= 4'h0;
			s.strapWait <= 2'h0;
			s.holdSelQ <= 2'h0;
			s.wdSelQ <= 2'h0;
			s.kickPrev <= 1'b0;
			s.divCnt <= '0;
			s.state <= ST_FORCED;
			s.holdCnt <= '0;
			s.wdCnt <= '0;
			s.refreshPulse <= 1'b0;
			s.resetN <= 1'b0;
			s.resetHigh <= 1'b1;
			s.cause <= CAUSE_SUPPLY;
		end else begin
			s <= next_s;
		end
	end

	assign resetN = s.resetN;
	assign resetHigh = s.resetHigh;
	// open-drain: pull low only while asserted, else leave the line free
	assign resetOdOut = 1'b0;
	assign resetOdOe = s.resetHigh;
	assign resetCause = s.cause;

endmodule // svwd_supervisor

`default_nettype wire

// >>> tb/svwd_chk.sv
/*
 * Checker for the supervisor: reset output forms, sources, hold, watchdog.
 * Assumes it is bound to svwd_supervisor and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none
module svwd_chk import svwd_pkg::*; #(
	parameter logic [CNT_W-1:0] HOLD_TICKS_A = HOLD_A_TICKS,
	parameter logic [CNT_W-1:0] HOLD_TICKS_B = HOLD_B_TICKS,
	parameter logic [CNT_W-1:0] HOLD_TICKS_C = HOLD_C_TICKS,
	parameter logic [CNT_W-1:0] HOLD_TICKS_D = HOLD_D_TICKS,
	parameter logic [CNT_W-1:0] WD_TICKS_W = WD_W_TICKS,
	parameter logic [CNT_W-1:0] WD_TICKS_X = WD_X_TICKS,
	parameter logic [CNT_W-1:0] WD_TICKS_Y = WD_Y_TICKS,
	parameter logic [CNT_W-1:0] WD_TICKS_Z = WD_Z_TICKS,
	parameter logic [DIV_W-1:0] TICK_LAST_CYC = TICK_LAST
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic manualResetN,
	input wire logic manualResetDriven,
	input wire logic watchdogKick,
	input wire logic watchdogKickDriven,
	input wire logic supplyAboveTrip,
	input wire logic [1:0] holdSel,
	input wire logic [1:0] wdSel,
	input wire logic resetN,
	input wire logic resetHigh,
	input wire logic resetOdOut,
	input wire logic resetOdOe,
	input wire svwd_cause_t resetCause
);
	int tc, holdCyc, wdCyc, lowCnt, staleCnt, floatCnt, supLowCnt;
	logic kickQ;
	function automatic int pick(input logic [1:0] s, input int a, b, c, d);
		return s == 2'h0 ? a : s == 2'h1 ? b : s == 2'h2 ? c : d;
	endfunction
	assign tc = int'(TICK_LAST_CYC) + 1;
	assign holdCyc = tc * pick(holdSel, int'(HOLD_TICKS_A), int'(HOLD_TICKS_B),
		int'(HOLD_TICKS_C), int'(HOLD_TICKS_D));
	assign wdCyc = tc * pick(wdSel, int'(WD_TICKS_W), int'(WD_TICKS_X),
		int'(WD_TICKS_Y), int'(WD_TICKS_Z));
	// stale count runs on the raw pin, so bounds allow sync latency
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			kickQ <= 1'b0;
			lowCnt <= 0;
			staleCnt <= 0;
			floatCnt <= 0;
			supLowCnt <= 0;
		end else begin
			supLowCnt <= supplyAboveTrip ? 0 : supLowCnt + 1;
			kickQ <= watchdogKick;
			lowCnt <= resetN ? 0 : lowCnt + 1;
			staleCnt <= (!resetN || !watchdogKickDriven || watchdogKick != kickQ) ? 0 : staleCnt + 1;
			floatCnt <= watchdogKickDriven ? 0 : floatCnt + 1;
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	property p_inv; resetHigh == !resetN; endproperty
	property p_od; resetOdOe == !resetN && resetOdOut == 1'b0; endproperty
	property p_mr; (manualResetDriven && !manualResetN) [*8] |-> !resetN; endproperty
	// long low supply counted in helper logic, beyond sync and filter latency
	property p_sup; supLowCnt >= 48 |-> !resetN; endproperty
	property p_hold; $rose(resetN) |-> lowCnt >= holdCyc; endproperty
	property p_late; staleCnt <= wdCyc + tc + 4; endproperty
	property p_early; $fell(resetN) && resetCause == CAUSE_WATCHDOG |-> staleCnt >= wdCyc - tc;
	endproperty
	property p_float; $fell(resetN) && resetCause == CAUSE_WATCHDOG |-> floatCnt < 4; endproperty
	a_inv: assert property (p_inv) else $error("active-high reset not inverse");
	a_od: assert property (p_od) else $error("open-drain enable wrong");
	a_mr: assert property (p_mr) else $error("manual low without reset");
	a_sup: assert property (p_sup) else $error("low supply without reset");
	a_hold: assert property (p_hold) else $error("reset released early");
	a_late: assert property (p_late) else $error("watchdog expiry missed");
	a_early: assert property (p_early) else $error("watchdog fired early");
	a_float: assert property (p_float) else $error("floating kick fired");
	c_mr: cover property ($fell(resetN) && resetCause == CAUSE_MANUAL);
	c_sup: cover property ($fell(resetN) && resetCause == CAUSE_SUPPLY);
	c_wd: cover property ($fell(resetN) && resetCause == CAUSE_WATCHDOG);
endmodule // svwd_chk
bind svwd_supervisor svwd_chk #(.HOLD_TICKS_A(HOLD_TICKS_A), .HOLD_TICKS_B(HOLD_TICKS_B),
	.HOLD_TICKS_C(HOLD_TICKS_C), .HOLD_TICKS_D(HOLD_TICKS_D), .WD_TICKS_W(WD_TICKS_W),
	.WD_TICKS_X(WD_TICKS_X), .WD_TICKS_Y(WD_TICKS_Y), .WD_TICKS_Z(WD_TICKS_Z),
	.TICK_LAST_CYC(TICK_LAST_CYC)) u_svwd_chk (.*);
`default_nettype wire

// >>> tb/svwd_cpu_model.sv
/*
 * Processor model servicing the kick pin from its main loop.
 * Assumes resetN from the supervisor holds it in reset.
 */
`timescale 1ns/1ps
`default_nettype none
module svwd_cpu_model (
	input wire logic ref_clk,
	input wire logic resetN,
	input wire logic hang,
	input wire logic floatKick,
	input wire logic [7:0] gap,
	output logic watchdogKick,
	output logic watchdogKickDriven
);
	int cnt;
	logic lvl;
	initial begin
		cnt = 0;
		lvl = 1'b1;
		watchdogKick = 1'b1;
		watchdogKickDriven = 1'b1;
	end
	always @(negedge ref_clk) begin
		if (!resetN) begin
			cnt = 0;
			lvl = 1'b1;
		end else if (!hang && ++cnt >= int'(gap)) begin
			cnt = 0;
			lvl = !lvl;
		end
		// released line shows the inverse of its last level, no pull
		watchdogKick <= floatKick ? (watchdogKickDriven ? !watchdogKick : watchdogKick) : lvl;
		watchdogKickDriven <= !floatKick;
	end
endmodule // svwd_cpu_model
`default_nettype wire

// >>> tb/tb.sv
/*
 * Testbench of the supervisor with a kicking processor model.
 * Assumes shortened periods: tick of 2 cycles, small hold and watchdog counts.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
	import svwd_pkg::*;
	localparam int TC = 2;
	logic ref_clk, rstn, mr, mrDrv, sup, resetN, resetHigh, odOut, odOe, hang, flt;
	logic [1:0] hSel;
	logic [7:0] gap;
	wire logic kick, kickDrv;
	svwd_cause_t cause;
	int mismatches, samplesChecked, cycles, n, k;
	// only the two shortest options are shortened and exercised
	svwd_supervisor #(.HOLD_TICKS_A(25'h3), .HOLD_TICKS_B(25'h4), .WD_TICKS_W(25'h14),
		.WD_TICKS_X(25'h18), .TICK_LAST_CYC(4'h1)) u_svwd_supervisor (.ref_clk(ref_clk),
		.rstn(rstn), .manualResetN(mr), .manualResetDriven(mrDrv), .watchdogKick(kick),
		.watchdogKickDriven(kickDrv), .supplyAboveTrip(sup), .holdSel(hSel), .wdSel(hSel),
		.resetN(resetN), .resetHigh(resetHigh), .resetOdOut(odOut), .resetOdOe(odOe),
		.resetCause(cause));
	svwd_cpu_model u_svwd_cpu_model (.ref_clk(ref_clk), .resetN(resetN), .hang(hang),
		.floatKick(flt), .gap(gap), .watchdogKick(kick), .watchdogKickDriven(kickDrv));
	function automatic int holdCyc(input int s); return (3 + s) * TC; endfunction
	function automatic int wdCyc(input int s); return (20 + 4 * s) * TC; endfunction
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %0h seen %0h", name, exp, seen);
		end
	endtask
	task automatic step(input int c); repeat (c) @(negedge ref_clk); endtask
	task automatic waitRst(input logic v, output int c);
		c = 0;
		while (resetN !== v && c < 5000) begin
			@(negedge ref_clk);
			c++;
		end
	endtask
	task automatic print_verdict;
		if (mismatches == 0 && samplesChecked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = !ref_clk;
	end
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 40000) begin
			mismatches++;
			print_verdict();
		end
	end
	initial begin
		{rstn, hang, flt, hSel} = 0;
		{mr, mrDrv, sup} = 3'h7;
		gap = 8'h8;
		void'($urandom(32'h99CE1AD8));
		for (int s = 0; s < 2; s++) begin
			hSel = 2'(s);
			rstn = 1'b0;
			step(6);
			rstn = 1'b1;
			waitRst(1'b1, n);
			check("powerUp", n >= 42 + holdCyc(s), 1);
			mr = 1'b0;
			step(8 + $urandom_range(0, 7));
			check("mrAssert", resetN, 0);
			check("mrCause", cause, CAUSE_MANUAL);
			check("odOe", {odOe, odOut}, 2'h2);
			check("resetHigh", resetHigh, 1);
			mr = 1'b1;
			waitRst(1'b1, n);
			check("mrHold", n >= holdCyc(s) && n <= holdCyc(s) + TC + 6, 1);
			mr = 1'b0;
			step(1);
			mr = 1'b1;
			step(20);
			check("mrGlitch", resetN, 1);
			mrDrv = 1'b0;
			step(3);
			mr = 1'b0;
			step(20);
			check("mrFloat", resetN, 1);
			mr = 1'b1;
			step(3);
			mrDrv = 1'b1;
			sup = 1'b0;
			step(5 + $urandom_range(0, 30));
			sup = 1'b1;
			step(10);
			check("supGlitch", resetN, 1);
			sup = 1'b0;
			step(60);
			check("supAssert", {resetN, cause}, {1'b0, CAUSE_SUPPLY});
			sup = 1'b1;
			waitRst(1'b1, n);
			check("supHold", n >= 40 + holdCyc(s), 1);
			gap = 8'($urandom_range(1, wdCyc(s) / 2));
			step(3 * wdCyc(s));
			check("kicked", resetN, 1);
			hang = 1'b1;
			waitRst(1'b0, n);
			check("wdFire", n >= wdCyc(s) - int'(gap) - TC && n <= wdCyc(s) + TC + 6, 1);
			check("wdCause", cause, CAUSE_WATCHDOG);
			waitRst(1'b1, n);
			check("wdHold", n >= holdCyc(s) - 1, 1);
			waitRst(1'b0, k);
			check("wdRestart", k >= wdCyc(s) - TC && k <= wdCyc(s) + TC + 6, 1);
			hang = 1'b0;
			waitRst(1'b1, n);
			flt = 1'b1;
			step(4 * wdCyc(s));
			check("kickFloat", resetN, 1);
			flt = 1'b0;
		end
		print_verdict();
	end
endmodule // tb
`default_nettype wire
